// ==== design/vrd_lpf.sv ====
// First-order digital low-pass filter for one analog command channel.
// Assumes samples arrive with a one-cycle valid strobe on the main clock.
`timescale 1ns/1ps
module vrd_lpf
  import vrd_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Sample in
  input  wire logic signed [VEL_W-1:0] sample_in,
  input  wire logic                    sample_valid,
  // Panel setting, unity at COEF_ONE
  input  wire logic [COEF_W-1:0]       filter_setting,
  // Filtered sample out
  output logic signed [VEL_W-1:0]      filtered_out,
  output logic                         filtered_valid
);

  logic signed [VEL_W-1:0]      y_q, y_d;
  logic                         v_q, v_d;
  logic [COEF_W-1:0]            coef;
  logic signed [DIFF_W-1:0]     err;
  logic signed [DIFF_W+COEF_W:0] prod;
  logic signed [DIFF_W+COEF_W:0] step;
  logic signed [DIFF_W:0]       sum;

  // Setting clamps at unity so the output never overshoots the input
  always_comb begin
    coef = (filter_setting > COEF_ONE) ? COEF_ONE : filter_setting;
    err  = DIFF_W'(sample_in) - DIFF_W'(y_q);
    prod = err * $signed({1'b0, coef});
    step = prod >>> COEF_FRAC;
    sum  = (DIFF_W+1)'(y_q) + step[DIFF_W:0];
    y_d  = sample_valid ? sum[VEL_W-1:0] : y_q;
    v_d  = sample_valid;
  end

  // Filter state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      y_q <= '0;
      v_q <= 1'b0;
    end else begin
      y_q <= y_d;
      v_q <= v_d;
    end
  end

  assign filtered_out   = y_q;
  assign filtered_valid = v_q;

  a_filt_hold_idle: assert property (@(posedge clock) disable iff (!rst_n)
    !sample_valid |=> $stable(filtered_out))
    else $error("filter output moved without a sample");

  a_filt_unity_pass: assert property (@(posedge clock) disable iff (!rst_n)
    sample_valid && filter_setting >= COEF_ONE |=> filtered_out == $past(sample_in))
    else $error("unity setting did not pass the sample through");

  c_filt_sample: cover property (@(posedge clock) disable iff (!rst_n)
    sample_valid && filter_setting < COEF_ONE);

endmodule

// ==== design/vrd_pkg.sv ====
// Constants shared by the velocity reach detector and its command filter.
// Assumes velocities arrive as signed whole revolutions per second.
package vrd_pkg;

  // Data widths
  localparam int unsigned VEL_W   = 16;
  localparam int unsigned DIFF_W  = VEL_W + 1;
  localparam int unsigned SEL_W   = 16;
  localparam int unsigned DISP_W  = 16;
  localparam int unsigned PROD_W  = 24;
  localparam int unsigned COEF_W  = 16;

  // Reach digit sits second from the right of the output selection word
  localparam int unsigned REACH_DIGIT_LSB = 4;
  localparam int unsigned DIGIT_W         = 4;
  localparam logic [3:0]  DIGIT_GP        = 4'h3;  // Default: plain output
  localparam logic [3:0]  DIGIT_INV       = 4'hB;  // Open once reached
  localparam logic [SEL_W-1:0] SEL_RESET  = 16'h0030;

  // Ripple window: panel value times scale, held within the legal span
  localparam logic [PROD_W-1:0] RIPPLE_SCALE   = 24'h0000F0;  // 240
  localparam logic [PROD_W-1:0] RIPPLE_MAX_RPS = 24'h000088;  // 136
  localparam logic [DIFF_W-1:0] RIPPLE_RESET   = 17'h00000;

  // Filter setting: value = 72090 / (1400/x + 2.2); its ceiling is unity
  localparam int unsigned FILT_NUM   = 72090;
  localparam int unsigned FILT_DIV   = 1400;
  localparam int unsigned FILT_OFS10 = 22;
  localparam int unsigned COEF_FRAC  = 15;
  localparam logic [COEF_W-1:0] COEF_ONE = 16'h8000;

  // Pin drive mode decoded from the reach digit
  typedef enum logic [1:0] {
    VRD_MODE_GP,
    VRD_MODE_NORMAL,
    VRD_MODE_INVERT
  } vrd_mode_t;

endpackage

// ==== design/vrd_top.sv ====
// Velocity reach detector with analog command filter.
// Assumes velocities and settings are synchronous to clock and valid each cycle.
// Functional notes
// - Velocity mode: drive reach indication on pin
// - Reach digit is second from right
// - Inverted digit: closed until reached, then open
// - Normal digit: closed when reached, else open
// - Default digit: reach disabled, plain output
// - Reached when difference within ripple window
// - Window equals panel value times 240; the code holds it at 136 rps for any nonzero value
// - Analog command samples pass low-pass filter
// - Filter setting follows cutoff relation
`timescale 1ns/1ps
module vrd_top
  import vrd_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Control mode and velocities
  input  wire logic                    velocity_mode,
  input  wire logic signed [VEL_W-1:0] actual_velocity,
  input  wire logic signed [VEL_W-1:0] command_velocity,
  // Settings
  input  wire logic [SEL_W-1:0]        output_function_select,
  input  wire logic [DISP_W-1:0]       reach_ripple_window,
  input  wire logic                    gp_out_level,
  // Analog command channel
  input  wire logic signed [VEL_W-1:0] analog_sample,
  input  wire logic                    analog_valid,
  input  wire logic [COEF_W-1:0]       filter_setting,
  // Outputs
  output logic                         reach_output_pin,
  output logic                         reach_status,
  output logic signed [VEL_W-1:0]      filtered_command,
  output logic                         filtered_valid
);

  // Pull the reach digit out of the selection word
  function automatic vrd_mode_t decode_mode(input logic [SEL_W-1:0] sel);
    logic [DIGIT_W-1:0] digit;
    digit = sel[REACH_DIGIT_LSB +: DIGIT_W];
    case (digit)
      DIGIT_GP:  decode_mode = VRD_MODE_GP;
      DIGIT_INV: decode_mode = VRD_MODE_INVERT;
      default:   decode_mode = VRD_MODE_NORMAL;
    endcase
  endfunction

  // Panel value to window in rps, held at the top of its span
  function automatic logic [DIFF_W-1:0] window_rps(input logic [DISP_W-1:0] disp);
    logic [PROD_W-1:0] prod;
    prod = PROD_W'(disp) * RIPPLE_SCALE;
    // Any nonzero panel value is at least 240 rps, so it always saturates
    if (prod > RIPPLE_MAX_RPS) begin
      prod = RIPPLE_MAX_RPS;
    end
    window_rps = prod[DIFF_W-1:0];
  endfunction

  // Combinational compare path
  vrd_mode_t                mode_c;
  logic [DIFF_W-1:0]        window_c;
  logic signed [DIFF_W-1:0] diff_c;
  logic [DIFF_W-1:0]        abs_c;
  logic                     within_c;
  logic                     reached_c;

  // Registered outputs, plus shadow copies of mode and window for checks
  logic                     pin_q, pin_d;
  logic                     stat_q, stat_d;
  vrd_mode_t                mode_q, mode_d;
  logic [DIFF_W-1:0]        win_q, win_d;

  // Comparison is combinational so the pin lags inputs by one clock only
  always_comb begin
    mode_c   = decode_mode(output_function_select);
    window_c = window_rps(reach_ripple_window);
    diff_c   = DIFF_W'(actual_velocity) - DIFF_W'(command_velocity);
    abs_c    = diff_c[DIFF_W-1] ? DIFF_W'(-diff_c) : DIFF_W'(diff_c);
    within_c = (abs_c <= window_c);
    reached_c = velocity_mode && within_c;
  end

  // Pin level: high means the output contact is closed
  always_comb begin
    mode_d = mode_c;
    win_d  = window_c;
    stat_d = reached_c;
    case (mode_c)
      VRD_MODE_GP:     pin_d = gp_out_level;
      VRD_MODE_NORMAL: pin_d = reached_c;
      VRD_MODE_INVERT: pin_d = !reached_c;
      default:         pin_d = 1'b0;
    endcase
  end

  // Output and status registers, re-evaluated on every clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_q  <= 1'b0;
      stat_q <= 1'b0;
      mode_q <= VRD_MODE_GP;
      win_q  <= RIPPLE_RESET;
    end else begin
      pin_q  <= pin_d;
      stat_q <= stat_d;
      mode_q <= mode_d;
      win_q  <= win_d;
    end
  end

  assign reach_output_pin = pin_q;
  assign reach_status     = stat_q;

  // Command channel filter
  vrd_lpf u_lpf (
    .clock          (clock),
    .rst_n          (rst_n),
    .sample_in      (analog_sample),
    .sample_valid   (analog_valid),
    .filter_setting (filter_setting),
    .filtered_out   (filtered_command),
    .filtered_valid (filtered_valid)
  );

  // Pin drive checks, one per reach state in the normal and inverted modes
  a_reach_closes: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_NORMAL && velocity_mode && within_c |=> reach_output_pin)
    else $error("normal mode did not close on reach");

  a_normal_open: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_NORMAL && !within_c |=> !reach_output_pin)
    else $error("normal mode closed before reach");

  a_invert_open: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_INVERT && velocity_mode && within_c |=> !reach_output_pin)
    else $error("inverted mode did not open on reach");

  a_invert_closed: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_INVERT && !within_c |=> reach_output_pin)
    else $error("inverted mode opened before reach");

  // Plain output follows its level one edge late
  a_gp_follows: assert property (@(posedge clock) disable iff (!rst_n)
    output_function_select[REACH_DIGIT_LSB +: DIGIT_W] == DIGIT_GP
    |=> reach_output_pin == $past(gp_out_level))
    else $error("plain output did not follow its level");

  // No reach outside velocity mode
  a_mode_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !velocity_mode |=> !reach_status)
    else $error("reach reported outside velocity mode");

  // Window scaling and its ceiling
  a_window_scale: assert property (@(posedge clock) disable iff (!rst_n)
    reach_ripple_window == 16'h0000 |=> win_q == RIPPLE_RESET)
    else $error("zero panel value gave a nonzero window");

  a_window_cap: assert property (@(posedge clock) disable iff (!rst_n)
    reach_ripple_window != 16'h0000 |=> win_q == DIFF_W'(RIPPLE_MAX_RPS))
    else $error("window not held at its ceiling");

  a_exact_zero: assert property (@(posedge clock) disable iff (!rst_n)
    reach_ripple_window == 16'h0000 && velocity_mode
    ##0 actual_velocity != command_velocity |=> !reach_status)
    else $error("zero window accepted unequal speeds");

  a_status_match: assert property (@(posedge clock) disable iff (!rst_n)
    velocity_mode && actual_velocity == command_velocity |=> reach_status ##1 1'b1)
    else $error("equal speeds not reported as reached");

  // Outside velocity mode the normal and inverted modes park at their not-reached level
  a_normal_idle: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_NORMAL && !velocity_mode |=> !reach_output_pin)
    else $error("normal mode closed outside velocity mode");

  a_invert_idle: assert property (@(posedge clock) disable iff (!rst_n)
    mode_c == VRD_MODE_INVERT && !velocity_mode |=> reach_output_pin)
    else $error("inverted mode opened outside velocity mode");

  // Status tracks the window test whatever the pin is doing
  a_status_within: assert property (@(posedge clock) disable iff (!rst_n)
    velocity_mode && abs_c <= window_c |=> reach_status)
    else $error("speed inside window not reported");

  a_status_outside: assert property (@(posedge clock) disable iff (!rst_n)
    abs_c > window_c |=> !reach_status)
    else $error("speed outside window reported as reached");

  // Digit decode seen through the registered mode
  a_digit_invert: assert property (@(posedge clock) disable iff (!rst_n)
    output_function_select[REACH_DIGIT_LSB +: DIGIT_W] == DIGIT_INV
    |=> mode_q == VRD_MODE_INVERT)
    else $error("inverted digit not decoded");

  a_digit_normal: assert property (@(posedge clock) disable iff (!rst_n)
    output_function_select[REACH_DIGIT_LSB +: DIGIT_W] != DIGIT_INV
    && output_function_select[REACH_DIGIT_LSB +: DIGIT_W] != DIGIT_GP
    |=> mode_q == VRD_MODE_NORMAL)
    else $error("other digit not decoded as normal");

  // Synchronous reset parks both outputs low one edge later
  a_reset_low: assert property (@(posedge clock)
    !rst_n |=> !reach_output_pin && !reach_status)
    else $error("outputs not cleared by reset");

  // Scenario covers
  c_reach_normal: cover property (@(posedge clock) disable iff (!rst_n)
    mode_q == VRD_MODE_NORMAL && reach_output_pin);

  c_reach_invert: cover property (@(posedge clock) disable iff (!rst_n)
    mode_q == VRD_MODE_INVERT && !reach_output_pin ##1 reach_output_pin);

  c_gp_high: cover property (@(posedge clock) disable iff (!rst_n)
    mode_q == VRD_MODE_GP && reach_output_pin);

  c_window_edge: cover property (@(posedge clock) disable iff (!rst_n)
    velocity_mode && window_c != '0 && abs_c == window_c);

endmodule

// ==== tb/test_velocity_reach_detector_filter.sv ====
// Self-checking bench for the velocity reach detector and command filter.
// Assumes vrd_top from design/ and the host model vrd_host from tb/.
`timescale 1ns/1ps
module test_velocity_reach_detector_filter
  import vrd_pkg::*;
;
  logic                    clock = 1'b0;
  logic                    rst_n, vm, gp, av;
  logic signed [VEL_W-1:0] act, cmd, smp, y_m;
  logic [SEL_W-1:0]        sel;
  logic [DISP_W-1:0]       win;
  logic [COEF_W-1:0]       coef;
  logic [3:0]              digs [6] = '{4'h3, 4'hB, 4'hA, 4'h0, 4'h1, 4'h9};
  logic                    pin, sts, fv, host;
  logic signed [VEL_W-1:0] fc, rc;
  logic                    last_pin = 1'b0;
  int                      bad_count = 0;
  int                      cmp_count = 0;

  vrd_top vrd_top_i (.clock(clock), .rst_n(rst_n), .velocity_mode(vm),
    .actual_velocity(act), .command_velocity(cmd), .output_function_select(sel),
    .reach_ripple_window(win), .gp_out_level(gp), .analog_sample(smp),
    .analog_valid(av), .filter_setting(coef), .reach_output_pin(pin),
    .reach_status(sts), .filtered_command(fc), .filtered_valid(fv));
  vrd_host vrd_host_i (.clock(clock), .reach_output_pin(pin), .host_closed_q(host));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // Window collapses to 136 rps for any nonzero panel value
  function automatic logic exp_sts(logic v, logic signed [VEL_W-1:0] a, c, logic [15:0] w);
    int d;
    d = int'(a) - int'(c);
    if (d < 0) d = -d;
    return v && (d <= ((w == 16'h0000) ? 0 : 136));
  endfunction

  function automatic logic exp_pin(logic s, logic [3:0] dg, logic g);
    if (dg == 4'h3) return g;
    return (dg == 4'hB) ? !s : s;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Apply one setting, then check the registered answer one edge later
  task automatic rstep(logic v, logic signed [VEL_W-1:0] a, c, logic [3:0] dg,
                       logic [15:0] w, logic g);
    logic s;
    logic p;
    @(posedge clock);
    vm <= v; act <= a; cmd <= c; win <= w; gp <= g;
    sel <= {8'($urandom), dg, 4'($urandom)};
    @(posedge clock);
    #1;
    s = exp_sts(v, a, c, w);
    p = exp_pin(s, dg, g);
    chk({31'h0, sts}, {31'h0, s});
    chk({31'h0, pin}, {31'h0, p});
    // Host samples the contact one edge behind, so it shows the previous step
    chk({31'h0, host}, {31'h0, last_pin});
    last_pin = p;
  endtask

  // One filter sample; model y += ((x-y)*k)>>>15 with k capped at unity
  task automatic fstep(logic signed [VEL_W-1:0] x, logic [15:0] k);
    longint p;
    @(posedge clock);
    smp <= x; av <= 1'b1; coef <= k;
    @(posedge clock);
    av <= 1'b0;
    #1;
    p = (longint'(x) - longint'(y_m)) * longint'((k > COEF_ONE) ? COEF_ONE : k);
    y_m = VEL_W'(longint'(y_m) + (p >>> 15));
    chk({31'h0, fv}, 32'h1);
    chk(32'(fc), 32'(y_m));
  endtask

  // Watchdog, far beyond the expected run of under 1000 cycles
  initial begin
    #20000;
    bad_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0; vm = 1'b0; gp = 1'b0; av = 1'b0; act = '0; cmd = '0;
    smp = '0; sel = SEL_RESET; win = '0; coef = COEF_ONE; y_m = '0;
    void'($urandom(32'hf58e3e34));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk({31'h0, pin}, 32'h0);
    rstep(1, 100, 100, 4'hA, 0, 0);
    rstep(1, 101, 100, 4'hA, 0, 1);
    rstep(1, 236, 100, 4'hB, 1, 0);
    rstep(1, -37, 100, 4'hB, 16'hFFFF, 1);
    rstep(0, 5, 5, 4'hB, 0, 0);
    rstep(1, 5, 5, 4'h3, 0, 1);
    rstep(1, 5, 5, 4'h3, 0, 0);
    repeat (300) begin
      rc = 16'(int'($urandom_range(20000)) - 10000);
      rstep($urandom_range(3) != 0, rc + 16'(int'($urandom_range(300)) - 150), rc,
            digs[$urandom_range(5)], ($urandom_range(1) == 1) ? 16'($urandom) : 16'h0000,
            1'($urandom));
    end
    fstep(100, 16'h8000);
    fstep(0, 16'h4000);
    repeat (60) fstep(16'($urandom), ($urandom_range(2) == 0) ? 16'hFFFF : 16'($urandom));
    // Mid-run reset for one edge clears every output and the filter state
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    #1;
    y_m = '0;
    chk({29'h0, pin, sts, fv}, 32'h0);
    chk(32'(fc), 32'h0);
    fstep(-200, 16'h2000);
    wrap_up();
  end
endmodule

// ==== tb/vrd_host.sv ====
// Host controller model: reads the reach contact once per clock.
// Assumes pin level 1 means the contact is closed.
`timescale 1ns/1ps
module vrd_host (
  // Clock and contact
  input  wire logic clock,
  input  wire logic reach_output_pin,
  // Host view of the contact
  output logic      host_closed_q
);
  // Host only listens; it never drives the drive back
  always_ff @(posedge clock) begin
    host_closed_q <= reach_output_pin;
  end
endmodule
